/* verilog/fpc_top.sv */
module fpc_top import fpc_pkg::*; (
  input  wire logic        pclk,          // system clock
  input  wire logic        presetn,       // async reset, active low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb direction
  input  wire logic [11:0] paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error
  input  wire logic        insn_step,     // core retired an instruction
  input  wire logic        xstore,        // external data store strobe
  input  wire logic [15:0] xaddr,         // store address (data pointer)
  input  wire logic [7:0]  xdata,         // store data
  output logic             buf_we,        // page buffer write pulse
  output logic [5:0]       buf_addr,      // page buffer location
  output logic [7:0]       buf_data,      // page buffer byte
  output logic             buf_clear,     // page buffer clear pulse
  output logic             xram_we,       // data memory write pulse
  input  wire logic        data_storage_space_rd,      // data storage read strobe
  input  wire logic        data_storage_space_wr,      // data storage write strobe
  input  wire logic [15:0] data_storage_space_addr,    // data storage address
  output logic             op_start,      // operation start pulse
  output logic [1:0]       op_target,     // space being programmed
  output logic             op_erase,      // erase phase active
  output logic             op_prog,       // program phase active
  output logic             op_multi,      // page load enable to buffer
  input  wire logic        supply_ok_pin, // supply above programming level
  input  wire logic        brownout_pin,  // brownout during operation
  input  wire logic        data_storage_space_fail     // data storage brownout event
);
  // block state, apart from the supply lockout timer
  typedef struct packed {
    logic [3:0]   key;     // launch key field
    logic         map;     // page buffer map bit
    logic [1:0]   tgt;     // memory target field
    logic         armed;   // first key seen
    logic         auto_erase_enable;    // auto erase enable
    logic         page_load_enable;    // page load enable
    logic         byte_flag_mode_enable;    // byte flag mode
    logic         flag_out_bit;    // flag out bit
    logic         err;     // error flag
    logic [15:0]  oplen;   // last count of each phase, one less than its cycles
    logic [15:0]  cnt;     // phase counter
    fpc_state_t   st;      // sequencer state
    logic [127:0] flags;   // byte flags
    logic [1:0]   sup_s;   // supply synchroniser
    logic [1:0]   bo_s;    // brownout synchroniser
    logic [31:0]  rdata;   // read data register
    logic         wbuf;    // buffer write pulse reg
    logic         wram;    // data memory write pulse reg
    logic [5:0]   baddr;   // buffer address reg
    logic [7:0]   bdata;   // buffer data reg
    logic         start;   // start pulse reg
  } fpc_st_t;
  fpc_st_t s_r, s_nxt;

  logic inhibit; // lockout flag from settle timer

  // flag range test
  function automatic logic in_flag_range(input logic [15:0] a);
    in_flag_range = (a >= FPC_FLAG_BASE) && (a <= (FPC_FLAG_BASE + 16'h007f));
  endfunction

  // launch register image
  function automatic logic [7:0] launch_img(input fpc_st_t s);
    launch_img = {s.key, s.map, s.tgt, (s.st != FPC_IDLE)};
  endfunction

  // supply lockout timer
  fpc_lockout #(.INH_CYC(FPC_INH_CYC)) u_lock (
    .pclk      (pclk),
    .presetn   (presetn),
    .supply_ok (s_r.sup_s[1]),
    .inhibit   (inhibit)
  );

  logic acc;   // apb access phase
  logic wr_l;  // write to launch register
  logic wr_c;  // write to control register
  logic busy;  // operation in progress
  logic [6:0] fidx; // flag index

  assign acc  = psel && penable;
  assign wr_l = acc && pwrite && (paddr == FPC_ADDR_LAUNCH);
  assign wr_c = acc && pwrite && (paddr == FPC_ADDR_NVCTL);
  assign busy = (s_r.st != FPC_IDLE);
  assign fidx = data_storage_space_addr[6:0];

  // next state logic
  always_comb begin
    s_nxt       = s_r;
    s_nxt.wbuf  = 1'b0;
    s_nxt.wram  = 1'b0;
    s_nxt.start = 1'b0;
    // synchronisers for pins
    s_nxt.sup_s = {s_r.sup_s[0], supply_ok_pin};
    s_nxt.bo_s  = {s_r.bo_s[0], brownout_pin};

    // a retired instruction that is not the second key breaks the pair
    if (insn_step && !wr_l) begin
      s_nxt.armed = 1'b0;
    end

    // launch register write
    if (wr_l && !busy) begin
      s_nxt.key = pwdata[FPC_KEY_MSB:FPC_KEY_LSB];
      s_nxt.map = pwdata[FPC_MAP_BIT];
      s_nxt.tgt = pwdata[FPC_TGT_MSB:FPC_TGT_LSB];
      if (pwdata[FPC_KEY_MSB:FPC_KEY_LSB] == FPC_KEY_FIRST) begin
        s_nxt.armed = 1'b1; // lone first key does nothing
      end else if (pwdata[FPC_KEY_MSB:FPC_KEY_LSB] == FPC_KEY_SECOND && s_r.armed) begin
        s_nxt.armed = 1'b0;
        if (pwdata[FPC_TGT_MSB:FPC_TGT_LSB] != FPC_TGT_RSVD && inhibit) begin
          s_nxt.start = 1'b1;
          s_nxt.cnt   = '0;
          s_nxt.st    = s_r.auto_erase_enable ? FPC_ERASE : FPC_PROG;
        end
      end else begin
        s_nxt.armed = 1'b0; // other key breaks the pair
      end
    end

    // control register write; error cleared only by software
    if (wr_c) begin
      s_nxt.auto_erase_enable  = pwdata[FPC_AUTO_ERASE_ENABLE_BIT];
      s_nxt.page_load_enable  = pwdata[FPC_PAGE_LOAD_ENABLE_BIT];
      s_nxt.byte_flag_mode_enable  = pwdata[FPC_BYTE_FLAG_MODE_ENABLE_BIT];
      s_nxt.err   = s_r.err & pwdata[FPC_ERR_BIT]; // writing zero clears
      s_nxt.oplen = s_r.oplen;
    end
    if (acc && pwrite && paddr == FPC_ADDR_OP) begin
      s_nxt.oplen = pwdata[15:0];
    end

    // store routing
    if (xstore) begin
      if (s_r.map) begin
        s_nxt.wbuf  = 1'b1;
        s_nxt.baddr = xaddr[5:0];
        s_nxt.bdata = xdata;
      end else begin
        s_nxt.wram  = 1'b1;
      end
    end

    // byte flags
    if (!s_nxt.byte_flag_mode_enable) begin
      s_nxt.flags = '0;
      s_nxt.flag_out_bit  = 1'b1;
    end else begin
      if (data_storage_space_wr && in_flag_range(data_storage_space_addr)) begin
        s_nxt.flags[fidx] = 1'b1;
      end
      if (data_storage_space_rd && in_flag_range(data_storage_space_addr)) begin
        s_nxt.flag_out_bit = s_r.flags[fidx];
      end
    end

    // sequencer: busy for whole operation
    case (s_r.st)
      FPC_IDLE: begin
        s_nxt.cnt = s_nxt.cnt;
      end
      FPC_ERASE: begin
        if (s_r.cnt >= s_r.oplen) begin
          s_nxt.cnt = '0;
          s_nxt.st  = FPC_PROG; // erase then program
        end else begin
          s_nxt.cnt = s_r.cnt + 16'h1;
        end
      end
      FPC_PROG: begin
        if (s_r.cnt >= s_r.oplen) begin
          s_nxt.st = FPC_CLEAN;
        end else begin
          s_nxt.cnt = s_r.cnt + 16'h1;
        end
      end
      FPC_CLEAN: begin
        s_nxt.st = FPC_IDLE; // busy drops here
      end
      default: begin
        s_nxt.st = FPC_IDLE;
      end
    endcase

    // brownout during an operation flags an error; set wins over clear
    if ((busy && s_r.bo_s[1]) || data_storage_space_fail) begin
      s_nxt.err = 1'b1;
    end

    // read data
    if (acc && !pwrite) begin
      if (paddr == FPC_ADDR_LAUNCH) begin
        s_nxt.rdata = {24'h0, launch_img(s_r)};
      end else if (paddr == FPC_ADDR_NVCTL) begin
        s_nxt.rdata = {24'h0, s_r.flag_out_bit, s_r.auto_erase_enable, s_r.page_load_enable, s_r.byte_flag_mode_enable,
                       inhibit, s_r.err, 2'b00};
      end else if (paddr == FPC_ADDR_OP) begin
        s_nxt.rdata = {16'h0, s_r.oplen};
      end else begin
        s_nxt.rdata = 32'h0;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r       <= '0;
      s_r.key   <= FPC_LAUNCH_RST[7:4];
      s_r.st    <= FPC_IDLE;
      s_r.flag_out_bit  <= 1'b1;
      s_r.oplen <= FPC_OP_CYC_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // apb: zero wait state, read data combinational from current state
  logic known; // mapped address
  assign known   = (paddr == FPC_ADDR_LAUNCH) || (paddr == FPC_ADDR_NVCTL) || (paddr == FPC_ADDR_OP);
  assign pready  = 1'b1;
  assign pslverr = acc && !known;
  always_comb begin
    if (paddr == FPC_ADDR_LAUNCH) begin
      prdata = {24'h0, launch_img(s_r)};
    end else if (paddr == FPC_ADDR_NVCTL) begin
      prdata = {24'h0, s_r.flag_out_bit, s_r.auto_erase_enable, s_r.page_load_enable, s_r.byte_flag_mode_enable, inhibit, s_r.err, 2'b00};
    end else if (paddr == FPC_ADDR_OP) begin
      prdata = {16'h0, s_r.oplen};
    end else begin
      prdata = 32'h0;
    end
  end

  // outputs
  assign buf_we    = s_r.wbuf;
  assign buf_addr  = s_r.baddr;
  assign buf_data  = s_r.bdata;
  assign buf_clear = (s_r.st == FPC_CLEAN);
  assign xram_we   = s_r.wram;
  assign op_start  = s_r.start;
  assign op_target = s_r.tgt;
  assign op_erase  = (s_r.st == FPC_ERASE);
  assign op_prog   = (s_r.st == FPC_PROG);
  assign op_multi  = s_r.page_load_enable;
endmodule

/* verilog/fpc_pkg.sv */
package fpc_pkg;
  // register offsets (byte addresses on apb, index * 4)
  localparam logic [7:0]  FPC_IDX_LAUNCH   = 8'hd1;  // launch register index
  localparam logic [7:0]  FPC_IDX_NVCTL    = 8'hd2;  // control/status register index
  localparam logic [11:0] FPC_ADDR_LAUNCH  = 12'h344; // byte address of launch register
  localparam logic [11:0] FPC_ADDR_NVCTL   = 12'h348; // byte address of control register
  localparam logic [11:0] FPC_ADDR_OP      = 12'h34c; // own: operation length register
  // launch register fields
  localparam int FPC_KEY_MSB    = 7;  // launch key field top
  localparam int FPC_KEY_LSB    = 4;  // launch key field bottom
  localparam int FPC_MAP_BIT    = 3;  // page buffer map bit
  localparam int FPC_TGT_MSB    = 2;  // target field top
  localparam int FPC_TGT_LSB    = 1;  // target field bottom
  localparam int FPC_BUSY_BIT   = 0;  // busy flag
  // control register fields
  localparam int FPC_FLAG_OUT_BIT_BIT   = 7;  // flag out
  localparam int FPC_AUTO_ERASE_ENABLE_BIT   = 6;  // auto erase enable
  localparam int FPC_PAGE_LOAD_ENABLE_BIT   = 5;  // page load enable
  localparam int FPC_BYTE_FLAG_MODE_ENABLE_BIT   = 4;  // byte flag mode enable
  localparam int FPC_INH_BIT    = 3;  // write lockout flag
  localparam int FPC_ERR_BIT    = 2;  // error flag
  // key and target values
  localparam logic [3:0] FPC_KEY_FIRST  = 4'h5; // first launch key
  localparam logic [3:0] FPC_KEY_SECOND = 4'ha; // second launch key
  localparam logic [1:0] FPC_TGT_CODE   = 2'h0; // code space
  localparam logic [1:0] FPC_TGT_SIG    = 2'h1; // signature space
  localparam logic [1:0] FPC_TGT_FUSE   = 2'h2; // fuse space
  localparam logic [1:0] FPC_TGT_RSVD   = 2'h3; // reserved, no action
  // reset values
  localparam logic [7:0] FPC_LAUNCH_RST = 8'h00; // launch register reset
  localparam logic [3:0] FPC_CTL_RST    = 4'h0;  // auto_erase_enable/page_load_enable/byte_flag_mode_enable/err reset
  // byte flag range 0780h..07ffh
  localparam logic [15:0] FPC_FLAG_BASE = 16'h0780; // flag range base
  localparam int          FPC_FLAGS     = 128;      // flags in range
  // timing: 2 ms lockout release at 40 MHz
  localparam int FPC_CLK_HZ      = 40000000;        // pclk rate
  localparam int FPC_INH_US      = 2000;            // lockout release delay in us
  localparam int FPC_INH_CYC     = FPC_INH_US * (FPC_CLK_HZ / 1000000); // 80000 cycles
  localparam logic [15:0] FPC_OP_CYC_RST = 16'h0100; // own: default operation length
  // sequencer states
  typedef enum logic [3:0] {
    FPC_IDLE  = 4'b0001, // waiting for launch
    FPC_ERASE = 4'b0010, // erasing page
    FPC_PROG  = 4'b0100, // programming page
    FPC_CLEAN = 4'b1000  // clearing page buffer
  } fpc_state_t;
endpackage

/* verilog/fpc_lockout.sv */
// supply lockout flag: low immediately, high after a settle delay
module fpc_lockout import fpc_pkg::*; #(
  parameter int INH_CYC = FPC_INH_CYC // settle cycles
) (
  input  wire logic pclk,      // system clock
  input  wire logic presetn,   // async reset, active low
  input  wire logic supply_ok, // synchronised supply good level
  output logic      inhibit    // write permitted flag
);
  typedef struct packed {
    logic [16:0] cnt; // settle counter
    logic        flg; // flag state
  } fpc_lk_t;
  fpc_lk_t s_r, s_nxt;

  // counts settle time while supply is good
  always_comb begin
    s_nxt = s_r;
    if (!supply_ok) begin // drop at once
      s_nxt.cnt = '0;
      s_nxt.flg = 1'b0;
    end else if (!s_r.flg) begin
      if (s_r.cnt >= 17'(INH_CYC - 1)) begin // delay elapsed
        s_nxt.flg = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 17'h1;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign inhibit = s_r.flg;
endmodule

/* tb/fpc_top_sva.sv */
// checker on the top ports of the flash programming control block
module fpc_top_sva import fpc_pkg::*; (
  input wire logic        pclk,      // clock
  input wire logic        presetn,   // reset, active low
  input wire logic        psel,      // apb select
  input wire logic        penable,   // apb access phase
  input wire logic        pwrite,    // apb direction
  input wire logic [11:0] paddr,     // apb address
  input wire logic [31:0] pwdata,    // apb write data
  input wire logic [31:0] prdata,    // apb read data
  input wire logic        xstore,    // store strobe
  input wire logic [15:0] xaddr,     // store address
  input wire logic [7:0]  xdata,     // store data
  input wire logic        buf_we,    // buffer write
  input wire logic [5:0]  buf_addr,  // buffer location
  input wire logic [7:0]  buf_data,  // buffer byte
  input wire logic        buf_clear, // buffer clear
  input wire logic        xram_we,   // data memory write
  input wire logic        op_start,  // start pulse
  input wire logic [1:0]  op_target, // space programmed
  input wire logic        op_erase,  // erase phase
  input wire logic        op_prog    // program phase
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;    // apb access edge
  logic key2;   // second key written
  logic rd_l;   // launch register read
  logic rd_c;   // control register read
  logic byte_flag_mode_enable_r; // mirror of byte flag mode
  assign acc  = psel && penable;
  assign key2 = acc && pwrite && paddr == FPC_ADDR_LAUNCH && pwdata[7:4] == FPC_KEY_SECOND;
  assign rd_l = acc && !pwrite && paddr == FPC_ADDR_LAUNCH;
  assign rd_c = acc && !pwrite && paddr == FPC_ADDR_NVCTL;
  // follow byte flag mode from software writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_flag_mode_enable_r <= 1'b0;
    end else if (acc && pwrite && paddr == FPC_ADDR_NVCTL) begin
      byte_flag_mode_enable_r <= pwdata[FPC_BYTE_FLAG_MODE_ENABLE_BIT];
    end
  end
  store_route_a: assert property (xstore |=> buf_we != xram_we)
    else $error("store reached neither or both targets");
  buf_copy_a: assert property (buf_we |-> buf_addr == $past(xaddr[5:0]) && buf_data == $past(xdata))
    else $error("buffer write carries wrong location or byte");
  store_cause_a: assert property ((buf_we || xram_we) |-> $past(xstore))
    else $error("write pulse without a store");
  start_key_a: assert property (op_start |-> $past(key2) || $past(key2, 2))
    else $error("operation started without second key");
  start_tgt_a: assert property (op_start |=> op_target != FPC_TGT_RSVD)
    else $error("operation started on reserved space");
  start_phase_a: assert property (op_start |-> ##[0:1] (op_erase || op_prog))
    else $error("start not followed by a phase");
  busy_read_a: assert property (rd_l && (op_erase || op_prog) |-> prdata[FPC_BUSY_BIT])
    else $error("busy reads low during operation");
  erase_prog_a: assert property ($fell(op_erase) |-> ##[0:1] op_prog)
    else $error("erase not followed by programming");
  clear_after_a: assert property ($fell(op_prog) |-> ##[0:2] buf_clear)
    else $error("buffer not cleared after operation");
  flag_out_bit_off_a: assert property (rd_c && !byte_flag_mode_enable_r |-> prdata[FPC_FLAG_OUT_BIT_BIT])
    else $error("flag out low while flag mode off");
  cover property (op_start);
  cover property ($fell(op_erase));
  cover property (buf_we);
endmodule

bind fpc_top fpc_top_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .xstore(xstore), .xaddr(xaddr),
  .xdata(xdata), .buf_we(buf_we), .buf_addr(buf_addr), .buf_data(buf_data), .buf_clear(buf_clear),
  .xram_we(xram_we), .op_start(op_start), .op_target(op_target), .op_erase(op_erase), .op_prog(op_prog));

/* tb/fpc_top_tb.sv */
module fpc_top_tb import fpc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, busy_seen;
  logic        insn_step, xstore, buf_we, buf_clear, xram_we, data_storage_space_rd, data_storage_space_wr, data_storage_space_fail;
  logic        op_start, op_erase, op_prog, op_multi, supply_ok_pin, brownout_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, bsnap, tgt;
  logic [15:0] xaddr, data_storage_space_addr;
  logic [7:0]  xdata, buf_data;
  logic [5:0]  buf_addr;
  logic [1:0]  op_target;
  int          failures, n_compared, n_start, n_erase, n_prog, n_clear, n_xram, n_buf, s, e, p, c, x, b;
  localparam logic [11:0] al = FPC_ADDR_LAUNCH; // launch register
  localparam logic [11:0] ac = FPC_ADDR_NVCTL;  // control register
  localparam int          ol = 4;               // shortened operation length
  fpc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .insn_step, .xstore, .xaddr, .xdata, .buf_we, .buf_addr, .buf_data, .buf_clear, .xram_we, .data_storage_space_rd,
    .data_storage_space_wr, .data_storage_space_addr, .op_start, .op_target, .op_erase, .op_prog, .op_multi, .supply_ok_pin,
    .brownout_pin, .data_storage_space_fail);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // tally output activity at each edge
  always @(posedge pclk) begin
    n_start += op_start;
    n_erase += op_erase;
    n_prog += op_prog;
    n_clear += buf_clear;
    n_xram += xram_we;
    n_buf += buf_we;
    if (buf_we) bsnap = {18'h0, buf_addr, buf_data};
    if (op_prog) tgt = {30'h0, op_target};
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v, input string w);
    apb(1'b0, a, 32'h0);
    chk(q & m, v, w);
  endtask
  task automatic store(input logic [15:0] a, input logic [7:0] d);
    @(posedge pclk);
    xstore <= 1'b1;
    xaddr <= a;
    xdata <= d;
    @(posedge pclk);
    xstore <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic edacc(input logic w, input logic [15:0] a);
    @(posedge pclk);
    data_storage_space_wr <= w;
    data_storage_space_rd <= !w;
    data_storage_space_addr <= a;
    @(posedge pclk);
    data_storage_space_wr <= 1'b0;
    data_storage_space_rd <= 1'b0;
  endtask
  // key pair, optionally split by a retired instruction, then poll busy
  task automatic launch(input logic [1:0] t, input logic brk);
    s = n_start;
    e = n_erase;
    p = n_prog;
    c = n_clear;
    apb(1'b1, al, {24'h0, FPC_KEY_FIRST, 1'b0, t, 1'b0});
    if (brk) begin
      @(posedge pclk);
      insn_step <= 1'b1;
      @(posedge pclk);
      insn_step <= 1'b0;
    end
    apb(1'b1, al, {24'h0, FPC_KEY_SECOND, 1'b0, t, 1'b0});
    apb(1'b0, al, 32'h0);
    busy_seen = q[FPC_BUSY_BIT];
    repeat (40) begin
      if (q[FPC_BUSY_BIT] !== 1'b1) break;
      apb(1'b0, al, 32'h0);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge pclk);
    failures++;
    $display("watchdog expired");
    complete_run();
  end
  initial begin
    {psel, penable, pwrite, insn_step, xstore, data_storage_space_rd, data_storage_space_wr, brownout_pin, data_storage_space_fail} = '0;
    {paddr, pwdata, xaddr, xdata, data_storage_space_addr} = '0;
    supply_ok_pin = 1'b1;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(al, 32'hff, 32'h00, "launch reset");
    rd(ac, 32'hff, 32'h80, "control reset");
    apb(1'b0, 12'h350, 32'h0);
    chk(err, 1'b1, "unmapped error");
    $display("registers done");
    x = n_xram;
    b = n_buf;
    store(16'h1234, 8'h5a);
    chk(n_xram - x, 1, "memory store");
    apb(1'b1, al, 32'h08);
    store(16'h12a5, 8'hc3);
    chk(n_buf - b, 1, "buffer store");
    chk(bsnap, 32'h25c3, "buffer byte");
    chk(n_xram - x, 1, "no memory store");
    apb(1'b1, al, 32'h00);
    $display("stores done");
    apb(1'b1, ac, 32'h10);
    edacc(1'b1, 16'h077f);
    edacc(1'b0, 16'h07ff);
    rd(ac, 32'h80, 32'h00, "flag outside range");
    edacc(1'b1, 16'h07ff);
    edacc(1'b0, 16'h07ff);
    rd(ac, 32'h80, 32'h80, "flag set");
    edacc(1'b0, 16'h0786);
    rd(ac, 32'h80, 32'h00, "flag clear");
    apb(1'b1, ac, 32'h20);
    rd(ac, 32'h80, 32'h80, "flag out off");
    @(posedge pclk);
    chk(op_multi, 1'b1, "page load");
    apb(1'b1, ac, 32'h10);
    edacc(1'b0, 16'h07ff);
    rd(ac, 32'h80, 32'h00, "flags reset");
    apb(1'b1, ac, 32'h00);
    $display("byte flags done");
    rd(ac, 32'h08, 32'h00, "lockout early");
    launch(2'h0, 1'b0);
    chk(n_start - s, 0, "locked start");
    repeat (FPC_INH_CYC) @(posedge pclk);
    rd(ac, 32'h08, 32'h08, "lockout release");
    apb(1'b1, FPC_ADDR_OP, ol);
    for (int t = 0; t < 4; t++) begin
      launch(2'(t), 1'b0);
      chk(n_start - s, t != 3, "start");
      chk(busy_seen, t != 3, "busy");
      chk(n_prog - p, (t != 3) ? ol + 1 : 0, "program cycles");
      chk(n_erase - e, 0, "erase cycles");
      chk(n_clear - c, t != 3, "buffer clear");
      chk(tgt, (t == 3) ? 2 : t, "target");
    end
    launch(2'h0, 1'b1);
    chk(n_start - s, 0, "split keys");
    apb(1'b1, al, 32'h50);
    rd(al, 32'h01, 32'h00, "lone key");
    apb(1'b1, al, 32'h00);
    apb(1'b1, ac, 32'h40);
    launch(2'h0, 1'b0);
    chk(n_erase - e, ol + 1, "auto erase");
    chk(n_prog - p, ol + 1, "erase then program");
    apb(1'b1, ac, 32'h00);
    brownout_pin <= 1'b1;
    launch(2'h1, 1'b0);
    brownout_pin <= 1'b0;
    rd(ac, 32'h04, 32'h04, "brownout error");
    apb(1'b1, ac, 32'h00);
    rd(ac, 32'h04, 32'h00, "error cleared");
    data_storage_space_fail <= 1'b1;
    @(posedge pclk);
    data_storage_space_fail <= 1'b0;
    rd(ac, 32'h04, 32'h04, "storage error");
    supply_ok_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(ac, 32'h08, 32'h00, "lockout drop");
    $display("programming done");
    complete_run();
  end
endmodule
